/* File: hdl/mcalu_core.sv */
module mcalu_core (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               core_id,
  input  wire logic               channel_id,
  input  wire mcalu_pkg::mcalu_req_t req,
  input  wire logic [15:0]        host_irq_status,
  input  wire logic [15:0]        exchange_in,
  input  wire logic               exchange_in_valid,
  output logic [15:0]             rd_data,
  output logic [15:0]             cond_word,
  output logic [5:0]              ram_addr_out,
  output logic [15:0]             instruction_pointer,
  output logic [15:0]             exchange_out,
  output logic [7:0]              backdoor_address,
  output mcalu_pkg::mcalu_dac_t   dac_out
);

  mcalu_pkg::mcalu_state_reg_t s;
  mcalu_pkg::mcalu_state_reg_t next_s;

  // Read mux used by register reads only; the operand paths index the register file directly.
  function automatic logic [15:0] read_sel(
    input mcalu_pkg::mcalu_state_reg_t st,
    input logic [4:0]  sel,
    input logic [15:0] irq
  );
    logic [15:0] v;
    v = 16'h0000;
    if (sel <= mcalu_pkg::SEL_PLOW)
      v = st.gen[sel[3:0]];
    else
      case (sel)
        mcalu_pkg::SEL_COND:     v = st.cond;
        mcalu_pkg::SEL_DAC_OO:   v = {2'h0, st.dac_oo};
        mcalu_pkg::SEL_DAC_PO:   v = {2'h0, st.dac_po};
        mcalu_pkg::SEL_DAC_OP:   v = {2'h0, st.dac_op};
        mcalu_pkg::SEL_DAC_PP:   v = {2'h0, st.dac_pp};
        mcalu_pkg::SEL_DAC_SHR:  v = {4'h0, st.dac_shr};
        mcalu_pkg::SEL_BACKDOOR: v = {8'h00, st.backdoor_address};
        mcalu_pkg::SEL_IRQ:      v = irq;
        mcalu_pkg::SEL_EXCHANGE: v = st.core_exchange_word;
        mcalu_pkg::SEL_IPTR:     v = st.instruction_pointer;
        default:                 v = 16'h0000;
      endcase
    return v;
  endfunction

  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [16:0] sum;
  logic        sgn_over;
  logic        sgn_under;
  logic        uns_over;
  logic        uns_under;
  logic [15:0] arith_res;
  logic [15:0] mask_res;
  logic [31:0] shift_res;
  logic        shift_bit;
  logic        accept;

  // Operands; the mask register is the second operand of mask ops.
  always_comb
  begin
    op_a = s.gen[{1'b0, req.src_a}];
    op_b = req.use_imm ? req.imm : s.gen[{1'b0, req.src_b}];
    if (req.alu_op inside {mcalu_pkg::MCALU_AND, mcalu_pkg::MCALU_OR,
                           mcalu_pkg::MCALU_XOR, mcalu_pkg::MCALU_NOT})
      op_b = s.gen[4'(mcalu_pkg::SEL_MASK)];
  end

  // Adder, overflow detection and limiting.
  always_comb
  begin
    if (req.alu_op == mcalu_pkg::MCALU_SUB)
      sum = {1'b0, op_a} - {1'b0, op_b};
    else
      sum = {1'b0, op_a} + {1'b0, op_b};
    uns_over  = (req.alu_op != mcalu_pkg::MCALU_SUB) && sum[16];
    uns_under = (req.alu_op == mcalu_pkg::MCALU_SUB) && sum[16];
    if (req.alu_op == mcalu_pkg::MCALU_SUB)
    begin
      sgn_over  = !op_a[15] && op_b[15] && sum[15];
      sgn_under = op_a[15] && !op_b[15] && !sum[15];
    end
    else
    begin
      sgn_over  = !op_a[15] && !op_b[15] && sum[15];
      sgn_under = op_a[15] && op_b[15] && !sum[15];
    end
    arith_res = sum[15:0];
    case (s.cond[mcalu_pkg::BIT_LIMIT_HI:mcalu_pkg::BIT_LIMIT_LO])
      mcalu_pkg::LIM_SIGNED:
      begin
        if (sgn_over)
          arith_res = mcalu_pkg::SAT_SPOS;
        else if (sgn_under)
          arith_res = mcalu_pkg::SAT_SNEG;
      end
      mcalu_pkg::LIM_UNSGN:
      begin
        if (uns_over)
          arith_res = mcalu_pkg::SAT_UMAX;
        else if (uns_under)
          arith_res = mcalu_pkg::SAT_UMIN;
      end
      default: arith_res = sum[15:0];
    endcase
  end

  // Mask and 32-bit shift of the product pair.
  always_comb
  begin
    case (req.alu_op)
      mcalu_pkg::MCALU_AND: mask_res = op_a & op_b;
      mcalu_pkg::MCALU_OR:  mask_res = op_a | op_b;
      mcalu_pkg::MCALU_XOR: mask_res = op_a ^ op_b;
      default:              mask_res = ~op_b;
    endcase
    if (req.alu_op == mcalu_pkg::MCALU_SHL)
    begin
      shift_res = {s.gen[6][14:0], s.gen[7], 1'b0};
      shift_bit = s.gen[6][15];
    end
    else
    begin
      shift_res = {1'b0, s.gen[6], s.gen[7][15:1]};
      shift_bit = s.gen[7][0];
    end
  end

  // ALU requests are ignored while a multi-cycle operation runs.
  assign accept = req.alu_valid && (s.state == mcalu_pkg::MCALU_IDLE);

  // Next-state logic for the whole block.
  always_comb
  begin
    next_s = s;
    next_s.rd_data = read_sel(s, req.rd_sel, host_irq_status);
    if (req.fetch)
      next_s.instruction_pointer = s.instruction_pointer + 16'h0001;
    if (req.jump)
      next_s.instruction_pointer = req.jump_addr;
    // Immediate address, optionally offset by the base register.
    next_s.ram_addr_out = req.ofs_enable ?
      6'(req.ram_addr + s.data_ram_offset_base) : req.ram_addr;
    if (req.set_base)
      next_s.data_ram_offset_base = req.base_value;
    if (exchange_in_valid)
      next_s.core_exchange_word = exchange_in;
    if (req.wr_valid)
    begin
      if (req.wr_sel <= mcalu_pkg::SEL_PLOW)
        next_s.gen[req.wr_sel[3:0]] = req.wr_data;
      else
        case (req.wr_sel)
          // The busy bit is not writable by the decoder.
          mcalu_pkg::SEL_COND:
            next_s.cond = {req.wr_data[15:1], s.cond[0]};
          mcalu_pkg::SEL_DAC_OO:   next_s.dac_oo = req.wr_data[13:0];
          mcalu_pkg::SEL_DAC_PO:   next_s.dac_po = req.wr_data[13:0];
          mcalu_pkg::SEL_DAC_OP:   next_s.dac_op = req.wr_data[13:0];
          mcalu_pkg::SEL_DAC_PP:   next_s.dac_pp = req.wr_data[13:0];
          mcalu_pkg::SEL_DAC_SHR:  next_s.dac_shr = req.wr_data[11:0];
          mcalu_pkg::SEL_BACKDOOR:
            next_s.backdoor_address = req.wr_data[7:0];
          mcalu_pkg::SEL_EXCHANGE: next_s.core_exchange_word = req.wr_data;
          default: ;
        endcase
    end
    case (s.state)
      mcalu_pkg::MCALU_IDLE:
      begin
        if (accept)
          case (req.alu_op)
            // Only flags of the executed class change.
            mcalu_pkg::MCALU_ADD, mcalu_pkg::MCALU_SUB:
            begin
              next_s.gen[{1'b0, req.dst}] = arith_res;
              next_s.cond[mcalu_pkg::BIT_CARRY]     = sum[16];
              next_s.cond[mcalu_pkg::BIT_SUM_ZERO]  = arith_res == 16'h0000;
              next_s.cond[mcalu_pkg::BIT_SUM_NEG]   = arith_res[15];
              next_s.cond[mcalu_pkg::BIT_UNS_UNDER] = uns_under;
              next_s.cond[mcalu_pkg::BIT_UNS_OVER]  = uns_over;
              next_s.cond[mcalu_pkg::BIT_SGN_UNDER] = sgn_under;
              next_s.cond[mcalu_pkg::BIT_SGN_OVER]  = sgn_over;
            end
            mcalu_pkg::MCALU_AND, mcalu_pkg::MCALU_OR,
            mcalu_pkg::MCALU_XOR, mcalu_pkg::MCALU_NOT:
            begin
              next_s.gen[{1'b0, req.dst}] = mask_res;
              next_s.cond[mcalu_pkg::BIT_MASK_ZERO] = mask_res == 16'h0000;
              next_s.cond[mcalu_pkg::BIT_MASK_ONES] = mask_res == 16'hffff;
            end
            mcalu_pkg::MCALU_SHL, mcalu_pkg::MCALU_SHR:
            begin
              next_s.gen[6] = shift_res[31:16];
              next_s.gen[7] = shift_res[15:0];
              next_s.cond[mcalu_pkg::BIT_SHIFT_OUT] = shift_bit;
              next_s.cond[mcalu_pkg::BIT_PROD_HIGH] = |shift_res[31:16];
              next_s.cond[mcalu_pkg::BIT_PROD_LOW]  = |shift_res[15:0];
            end
            mcalu_pkg::MCALU_TOINT:
            begin
              // A negative value loses its sign; the sign product is kept.
              next_s.gen[{1'b0, req.dst}] = op_a[15] ?
                16'(-op_a) : op_a;
              next_s.cond[mcalu_pkg::BIT_CONV_SIGN] = req.conv_reset ?
                op_a[15] : (s.cond[mcalu_pkg::BIT_CONV_SIGN] ^ op_a[15]);
            end
            mcalu_pkg::MCALU_MUL:
            begin
              next_s.mul_res = op_a * op_b;
              next_s.mul_cnt = 3'h0;
              next_s.mul_dst = req.dst;
              next_s.cond[mcalu_pkg::BIT_OP_DONE] = 1'b0;
              next_s.state = mcalu_pkg::MCALU_BUSY;
            end
            default: ;
          endcase
      end
      mcalu_pkg::MCALU_BUSY:
      begin
        // Multiply modelled as a fixed multi-cycle latency.
        next_s.mul_cnt = s.mul_cnt + 3'h1;
        if (s.mul_cnt == mcalu_pkg::MUL_LAST)
        begin
          next_s.gen[6] = s.mul_res[31:16];
          next_s.gen[7] = s.mul_res[15:0];
          next_s.cond[mcalu_pkg::BIT_PROD_HIGH] = |s.mul_res[31:16];
          next_s.cond[mcalu_pkg::BIT_PROD_LOW]  = |s.mul_res[15:0];
          next_s.cond[mcalu_pkg::BIT_OP_DONE] = 1'b1;
          next_s.state = mcalu_pkg::MCALU_IDLE;
        end
      end
      default: next_s.state = mcalu_pkg::MCALU_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s <= '0;
      s.cond <= mcalu_pkg::COND_RESET;
      s.state <= mcalu_pkg::MCALU_IDLE;
    end
    else
      s <= next_s;
  end

  // DAC routing by core and channel pairing.
  always_comb
  begin
    dac_out.dac_shared_high_negative = s.dac_shr;
    case ({channel_id, core_id})
      2'h0:
      begin
        dac_out.dac1 = s.dac_oo;
        dac_out.dac2 = s.dac_po;
        dac_out.dac3 = s.dac_op;
        dac_out.dac_four_low = s.dac_pp;
      end
      2'h1:
      begin
        dac_out.dac2 = s.dac_oo;
        dac_out.dac1 = s.dac_po;
        dac_out.dac_four_low = s.dac_op;
        dac_out.dac3 = s.dac_pp;
      end
      2'h2:
      begin
        dac_out.dac3 = s.dac_oo;
        dac_out.dac_four_low = s.dac_po;
        dac_out.dac1 = s.dac_op;
        dac_out.dac2 = s.dac_pp;
      end
      default:
      begin
        dac_out.dac_four_low = s.dac_oo;
        dac_out.dac3 = s.dac_po;
        dac_out.dac2 = s.dac_op;
        dac_out.dac1 = s.dac_pp;
      end
    endcase
  end

  assign rd_data             = s.rd_data;
  assign cond_word           = s.cond;
  assign ram_addr_out        = s.ram_addr_out;
  assign instruction_pointer = s.instruction_pointer;
  assign exchange_out        = s.core_exchange_word;
  assign backdoor_address    = s.backdoor_address;

  // Busy bit stays low for the whole multiply.
  busy_low_a: assert property (@(posedge mclk) disable iff (rst)
    (accept && req.alu_op == mcalu_pkg::MCALU_MUL) |=>
      !cond_word[0] [*4] ##1 cond_word[0])
    else $error("busy bit timing wrong");

  // Fetch advances the pointer by one.
  ptr_incr_a: assert property (@(posedge mclk) disable iff (rst)
    (req.fetch && !req.jump) |=>
      instruction_pointer == $past(instruction_pointer) + 16'h0001)
    else $error("pointer did not advance");

  // Signed saturation result, checked where it lands in the register.
  sat_signed_a: assert property (@(posedge mclk) disable iff (rst)
    (accept && req.alu_op == mcalu_pkg::MCALU_ADD && sgn_over &&
     cond_word[12:11] == 2'h1) |=>
      s.gen[$past(req.dst)] == 16'h7fff)
    else $error("signed clamp wrong");

  // Unsigned saturation result, checked where it lands in the register.
  sat_unsigned_a: assert property (@(posedge mclk) disable iff (rst)
    (accept && uns_under && cond_word[12:11] == 2'h3) |=>
      s.gen[$past(req.dst)] == 16'h0000)
    else $error("unsigned clamp wrong");

  // Wrapping modes keep the low sixteen bits of the raw sum.
  wrap_mode_a: assert property (@(posedge mclk) disable iff (rst)
    (accept && req.alu_op inside {mcalu_pkg::MCALU_ADD, mcalu_pkg::MCALU_SUB}
     && !cond_word[11]) |=> s.gen[$past(req.dst)] == $past(sum[15:0]))
    else $error("wrap result wrong");

  // A decoder write to the exchange word lands on the next edge.
  exch_write_a: assert property (@(posedge mclk) disable iff (rst)
    (req.wr_valid && req.wr_sel == mcalu_pkg::SEL_EXCHANGE) |=>
      exchange_out == $past(req.wr_data))
    else $error("exchange write lost");

  // Mask zero flag follows the result.
  mask_flag_a: assert property (@(posedge mclk) disable iff (rst)
    (accept && req.alu_op == mcalu_pkg::MCALU_AND) |=>
      cond_word[10] == (s.gen[$past(req.dst)] == 16'h0000))
    else $error("mask zero flag wrong");

  // Carry follows the adder.
  carry_flag_a: assert property (@(posedge mclk) disable iff (rst)
    (accept && req.alu_op == mcalu_pkg::MCALU_ADD) |=>
      cond_word[13] == $past(sum[16]))
    else $error("carry flag wrong");

  // Offset only when enabled.
  ram_offset_a: assert property (@(posedge mclk) disable iff (rst)
    !req.ofs_enable |=> ram_addr_out == $past(req.ram_addr))
    else $error("offset applied wrongly");

  // Interrupt copy is live.
  irq_copy_a: assert property (@(posedge mclk) disable iff (rst)
    (req.rd_sel == mcalu_pkg::SEL_IRQ) |=> rd_data == $past(host_irq_status))
    else $error("irq copy stale");

endmodule

/* File: include/mcalu_pkg.sv */
package mcalu_pkg;

  // Register selectors used by copy, load and store operations.
  localparam logic [4:0] SEL_GEN0      = 5'h00;
  localparam logic [4:0] SEL_GEN1      = 5'h01;
  localparam logic [4:0] SEL_GEN2      = 5'h02;
  localparam logic [4:0] SEL_GEN3      = 5'h03;
  localparam logic [4:0] SEL_GEN4      = 5'h04;
  localparam logic [4:0] SEL_MASK      = 5'h05;
  localparam logic [4:0] SEL_PHIGH     = 5'h06;
  localparam logic [4:0] SEL_PLOW      = 5'h07;
  localparam logic [4:0] SEL_COND      = 5'h08;
  localparam logic [4:0] SEL_DAC_OO    = 5'h09;
  localparam logic [4:0] SEL_DAC_PO    = 5'h0a;
  localparam logic [4:0] SEL_DAC_OP    = 5'h0b;
  localparam logic [4:0] SEL_DAC_PP    = 5'h0c;
  localparam logic [4:0] SEL_DAC_SHR   = 5'h0d;
  localparam logic [4:0] SEL_BACKDOOR  = 5'h0e;
  localparam logic [4:0] SEL_IRQ       = 5'h0f;
  localparam logic [4:0] SEL_EXCHANGE  = 5'h10;
  localparam logic [4:0] SEL_IPTR      = 5'h11;

  // Condition word bit positions.
  localparam int BIT_SHIFT_OUT  = 15;
  localparam int BIT_CONV_SIGN  = 14;
  localparam int BIT_CARRY      = 13;
  localparam int BIT_LIMIT_HI   = 12;
  localparam int BIT_LIMIT_LO   = 11;
  localparam int BIT_MASK_ZERO  = 10;
  localparam int BIT_MASK_ONES  = 9;
  localparam int BIT_PROD_HIGH  = 8;
  localparam int BIT_PROD_LOW   = 7;
  localparam int BIT_SUM_ZERO   = 6;
  localparam int BIT_SUM_NEG    = 5;
  localparam int BIT_UNS_UNDER  = 4;
  localparam int BIT_UNS_OVER   = 3;
  localparam int BIT_SGN_UNDER  = 2;
  localparam int BIT_SGN_OVER   = 1;
  localparam int BIT_OP_DONE    = 0;

  // Field layouts of the DAC setup words.
  localparam int DAC_OFS_MSB    = 13;
  localparam int DAC_OFS_LSB    = 8;
  localparam int DAC_LVL_MSB    = 7;
  localparam int DAC_NEG_MSB    = 11;
  localparam int DAC_NEG_LSB    = 8;

  // Reset values, cycle counts and saturation limits.
  localparam logic [15:0] COND_RESET  = 16'h0001;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam int          MUL_CYCLES  = 4;
  localparam logic [2:0]  MUL_LAST    = 3'h3;
  localparam logic [15:0] SAT_SPOS    = 16'h7fff;
  localparam logic [15:0] SAT_SNEG    = 16'h8000;
  localparam logic [15:0] SAT_UMAX    = 16'hffff;
  localparam logic [15:0] SAT_UMIN    = 16'h0000;

  // Limiting modes of the add_limit_mode field.
  localparam logic [1:0] LIM_WRAP_A = 2'h0;
  localparam logic [1:0] LIM_SIGNED = 2'h1;
  localparam logic [1:0] LIM_WRAP_B = 2'h2;
  localparam logic [1:0] LIM_UNSGN  = 2'h3;

  typedef enum logic [3:0] {
    MCALU_NOP, MCALU_ADD, MCALU_SUB, MCALU_AND, MCALU_OR, MCALU_XOR,
    MCALU_NOT, MCALU_MUL, MCALU_SHL, MCALU_SHR, MCALU_TOINT
  } mcalu_op_t;

  typedef enum logic [0:0] {MCALU_IDLE, MCALU_BUSY} mcalu_state_t;

  // One request from the instruction decoder.
  typedef struct packed {
    logic        alu_valid;
    mcalu_op_t   alu_op;
    logic [2:0]  src_a;
    logic [2:0]  src_b;
    logic [2:0]  dst;
    logic [15:0] imm;
    logic        use_imm;
    logic        conv_reset;
    logic        wr_valid;
    logic [4:0]  wr_sel;
    logic [15:0] wr_data;
    logic [4:0]  rd_sel;
    logic        set_base;
    logic [5:0]  base_value;
    logic [5:0]  ram_addr;
    logic        ofs_enable;
    logic        fetch;
    logic        jump;
    logic [15:0] jump_addr;
  } mcalu_req_t;

  // Static DAC outputs toward the current-measurement blocks.
  typedef struct packed {
    logic [13:0] dac1;
    logic [13:0] dac2;
    logic [13:0] dac3;
    logic [13:0] dac_four_low;
    logic [11:0] dac_shared_high_negative;
  } mcalu_dac_t;

  typedef struct packed {
    mcalu_state_t state;
    logic [2:0]   mul_cnt;
    logic [2:0]   mul_dst;
    logic [31:0]  mul_res;
    logic [15:0][15:0] gen;
    logic [15:0]  cond;
    logic [13:0]  dac_oo;
    logic [13:0]  dac_po;
    logic [13:0]  dac_op;
    logic [13:0]  dac_pp;
    logic [11:0]  dac_shr;
    logic [7:0]   backdoor_address;
    logic [15:0]  core_exchange_word;
    logic [15:0]  instruction_pointer;
    logic [5:0]   data_ram_offset_base;
    logic [15:0]  rd_data;
    logic [5:0]   ram_addr_out;
  } mcalu_state_reg_t;

endpackage

/* File: dv/mcalu_decoder_model.sv */
// Behavioural stand-in for the instruction decoder that drives the core.
module mcalu_decoder_model (
  input  wire logic               mclk,
  input  wire logic [15:0]        cond_word,
  input  wire logic [15:0]        rd_data,
  output mcalu_pkg::mcalu_req_t   req
);
  timeunit 1ns;
  timeprecision 1ps;

  // The request bus idles at zero so no pulse is seen during reset.
  initial req = '0;

  // Raise a request after an edge and drop it at the edge that takes it.
  task automatic send(input mcalu_pkg::mcalu_req_t r);
    @(posedge mclk);
    req <= r;
    @(posedge mclk);
    req <= '0;
    #1;
  endtask

  // A bounded poll, so a stuck busy bit cannot hang the decoder.
  task automatic wait_done();
    int n;
    n = 0;
    while (cond_word[0] !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  // A polite decoder waits for the done bit; rude lets a scenario break that.
  task automatic alu(input mcalu_pkg::mcalu_op_t op, input logic [2:0] a,
                     input logic [2:0] dst, input logic crst,
                     input logic rude);
    mcalu_pkg::mcalu_req_t r;
    r = '0;
    r.alu_valid = 1'b1;
    r.alu_op = op;
    r.src_a = a;
    r.src_b = 3'h1;
    r.dst = dst;
    r.conv_reset = crst;
    if (!rude)
      wait_done();
    send(r);
  endtask

  // Copy or load into a selected register.
  task automatic wr(input logic [4:0] s, input logic [15:0] d);
    mcalu_pkg::mcalu_req_t r;
    r = '0;
    r.wr_valid = 1'b1;
    r.wr_sel = s;
    r.wr_data = d;
    send(r);
  endtask

  // Copy or store from a selected register; data follows one edge later.
  task automatic rd(input logic [4:0] s, output logic [15:0] d);
    mcalu_pkg::mcalu_req_t r;
    r = '0;
    r.rd_sel = s;
    send(r);
    d = rd_data;
  endtask

  // Sequencer-side pulses: fetch, jump, base load and Data RAM addressing.
  task automatic misc(input logic f, input logic j, input logic [15:0] ja,
                      input logic sb, input logic [5:0] b,
                      input logic [5:0] ra, input logic ofs);
    mcalu_pkg::mcalu_req_t r;
    r = '0;
    r.fetch = f;
    r.jump = j;
    r.jump_addr = ja;
    r.set_base = sb;
    r.base_value = b;
    r.ram_addr = ra;
    r.ofs_enable = ofs;
    send(r);
  endtask
endmodule

/* File: dv/mcalu_core_bench.sv */
module mcalu_core_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  mclk, rst, core_id, channel_id, exchange_in_valid;
  logic [15:0]           host_irq_status, exchange_in, rd_data, cond_word;
  logic [15:0]           instruction_pointer, exchange_out, d;
  logic [5:0]            ram_addr_out;
  logic [7:0]            backdoor_address;
  mcalu_pkg::mcalu_req_t req;
  mcalu_pkg::mcalu_dac_t dac_out;
  logic [15:0]           vals [4];
  int                    miscompares, compares, cycles;

  // Free-running 200 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  mcalu_core dut (.mclk(mclk), .rst(rst), .core_id(core_id),
    .channel_id(channel_id), .req(req), .host_irq_status(host_irq_status),
    .exchange_in(exchange_in), .exchange_in_valid(exchange_in_valid),
    .rd_data(rd_data), .cond_word(cond_word), .ram_addr_out(ram_addr_out),
    .instruction_pointer(instruction_pointer), .exchange_out(exchange_out),
    .backdoor_address(backdoor_address), .dac_out(dac_out));

  mcalu_decoder_model dec (.mclk(mclk), .cond_word(cond_word),
    .rd_data(rd_data), .req(req));

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Case inequality so an unknown never passes for a match.
  task automatic chk(input string name, input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rdchk(input logic [4:0] s, input logic [15:0] e);
    dec.rd(s, d);
    chk($sformatf("register %h", s), d, e);
  endtask

  // Hang guard sized well above the few hundred cycles the tests need.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      final_report();
    end
  end

  task automatic t_regs();
    chk("cond reset", cond_word, 16'h0001);
    chk("ip reset", instruction_pointer, 16'h0000);
    dec.wr(mcalu_pkg::SEL_BACKDOOR, 16'h00a5);
    chk("backdoor", backdoor_address, 8'ha5);
    rdchk(mcalu_pkg::SEL_BACKDOOR, 16'h00a5);
    @(posedge mclk);
    host_irq_status <= 16'h5a3c;
    dec.wr(mcalu_pkg::SEL_IRQ, 16'h0000);
    rdchk(mcalu_pkg::SEL_IRQ, 16'h5a3c);
    @(posedge mclk);
    host_irq_status <= 16'hc3a5;
    rdchk(mcalu_pkg::SEL_IRQ, 16'hc3a5);
    @(posedge mclk);
    exchange_in <= 16'h1357;
    exchange_in_valid <= 1'b1;
    @(posedge mclk);
    exchange_in_valid <= 1'b0;
    #1;
    chk("exchange in", exchange_out, 16'h1357);
    rdchk(mcalu_pkg::SEL_EXCHANGE, 16'h1357);
    dec.wr(mcalu_pkg::SEL_EXCHANGE, 16'h2468);
    chk("exchange wr", exchange_out, 16'h2468);
    dec.wr(mcalu_pkg::SEL_MASK, 16'hbeef);
    rdchk(mcalu_pkg::SEL_MASK, 16'hbeef);
    rdchk(5'h1f, 16'h0000);
  endtask

  // Each strap pairing sees the four words in its own permuted order.
  task automatic t_dac();
    vals = '{16'h2a11, 16'h1522, 16'h0c33, 16'h3344};
    for (int j = 0; j < 4; j++)
      dec.wr(mcalu_pkg::SEL_DAC_OO + 5'(j), vals[j]);
    dec.wr(mcalu_pkg::SEL_DAC_SHR, 16'hfabc);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk);
      core_id <= k[0];
      channel_id <= k[1];
      #1;
      chk("dac map", {dac_out.dac1, dac_out.dac2, dac_out.dac3,
        dac_out.dac_four_low}, {vals[k][13:0], vals[1 ^ k][13:0],
        vals[2 ^ k][13:0], vals[3 ^ k][13:0]});
    end
    chk("dac shared", dac_out.dac_shared_high_negative, 12'habc);
    rdchk(mcalu_pkg::SEL_DAC_SHR, 16'h0abc);
    rdchk(mcalu_pkg::SEL_DAC_OP, 16'h0c33);
  endtask

  task automatic t_seq();
    dec.misc(1'b0, 1'b0, 16'h0, 1'b1, 6'h07, 6'h01, 1'b1);
    dec.misc(1'b0, 1'b0, 16'h0, 1'b0, 6'h00, 6'h01, 1'b1);
    chk("ofs addr", ram_addr_out, 6'h08);
    dec.misc(1'b0, 1'b0, 16'h0, 1'b0, 6'h00, 6'h21, 1'b0);
    chk("imm addr", ram_addr_out, 6'h21);
    repeat (3) dec.misc(1'b1, 1'b0, 16'h0, 1'b0, 6'h0, 6'h0, 1'b0);
    chk("ip count", instruction_pointer, 16'h0003);
    dec.misc(1'b0, 1'b1, 16'hfffe, 1'b0, 6'h0, 6'h0, 1'b0);
    repeat (2) dec.misc(1'b1, 1'b0, 16'h0, 1'b0, 6'h0, 6'h0, 1'b0);
    chk("ip wrap", instruction_pointer, 16'h0000);
  endtask

  // Flags are packed zero, negative, uu, uo, su, so.
  task automatic run_add(input logic [1:0] m, input logic sub,
                         input logic [15:0] a, b, res,
                         input logic [5:0] fl, input logic c);
    dec.wr(mcalu_pkg::SEL_COND, {3'h0, m, 11'h000});
    dec.wr(mcalu_pkg::SEL_GEN0, a);
    dec.wr(mcalu_pkg::SEL_GEN1, b);
    dec.alu(sub ? mcalu_pkg::MCALU_SUB : mcalu_pkg::MCALU_ADD, 3'h0, 3'h2,
            1'b0, 1'b0);
    chk("sum flags", cond_word[6:1], fl);
    if (!sub)
      chk("carry", cond_word[13], c);
    rdchk(mcalu_pkg::SEL_GEN2, res);
  endtask

  // Add flags from the last sum must survive every mask operation.
  task automatic run_mask(input mcalu_pkg::mcalu_op_t op,
                          input logic [15:0] res, input logic [1:0] fl);
    dec.alu(op, 3'h0, 3'h3, 1'b0, 1'b0);
    chk("mask flags", cond_word[10:9], fl);
    chk("kept flags", cond_word[6:1], 6'h28);
    rdchk(mcalu_pkg::SEL_GEN3, res);
  endtask

  task automatic run_prod(input mcalu_pkg::mcalu_op_t op,
                          input logic [15:0] hi, lo, input logic [2:0] fl);
    dec.alu(op, 3'h0, 3'h1, 1'b0, 1'b0);
    dec.wait_done();
    chk("prod flags", {cond_word[15], cond_word[8:7]}, fl);
    rdchk(mcalu_pkg::SEL_PHIGH, hi);
    rdchk(mcalu_pkg::SEL_PLOW, lo);
  endtask

  task automatic t_mul();
    dec.wr(mcalu_pkg::SEL_GEN0, 16'h0100);
    dec.wr(mcalu_pkg::SEL_GEN1, 16'h0100);
    dec.alu(mcalu_pkg::MCALU_MUL, 3'h0, 3'h0, 1'b0, 1'b0);
    chk("busy", cond_word[0], 1'b0);
    dec.alu(mcalu_pkg::MCALU_ADD, 3'h0, 3'h3, 1'b0, 1'b1);
    @(posedge mclk);
    #1;
    chk("busy end", cond_word[0], 1'b0);
    @(posedge mclk);
    #1;
    chk("done", cond_word[0], 1'b1);
    rdchk(mcalu_pkg::SEL_GEN3, 16'hff00);
    run_prod(mcalu_pkg::MCALU_NOP, 16'h0001, 16'h0000, 3'b010);
    dec.wr(mcalu_pkg::SEL_GEN0, 16'h0003);
    dec.wr(mcalu_pkg::SEL_GEN1, 16'h0002);
    run_prod(mcalu_pkg::MCALU_MUL, 16'h0000, 16'h0006, 3'b001);
    dec.wr(mcalu_pkg::SEL_PHIGH, 16'h8000);
    dec.wr(mcalu_pkg::SEL_PLOW, 16'h0001);
    run_prod(mcalu_pkg::MCALU_SHL, 16'h0000, 16'h0002, 3'b101);
    run_prod(mcalu_pkg::MCALU_SHR, 16'h0000, 16'h0001, 3'b001);
    run_prod(mcalu_pkg::MCALU_SHR, 16'h0000, 16'h0000, 3'b100);
  endtask

  // Immediate operand replaces the second register in an addition.
  task automatic t_imm();
    mcalu_pkg::mcalu_req_t r;
    r = '0;
    r.alu_valid = 1'b1;
    r.alu_op = mcalu_pkg::MCALU_ADD;
    r.use_imm = 1'b1;
    r.imm = 16'h0003;
    r.dst = 3'h4;
    dec.wr(mcalu_pkg::SEL_COND, 16'h0000);
    dec.wr(mcalu_pkg::SEL_GEN0, 16'hffff);
    dec.send(r);
    chk("imm carry", cond_word[13], 1'b1);
    rdchk(mcalu_pkg::SEL_GEN4, 16'h0002);
  endtask

  task automatic run_toint(input logic [15:0] v, input logic crst, s);
    dec.wr(mcalu_pkg::SEL_GEN0, v);
    dec.alu(mcalu_pkg::MCALU_TOINT, 3'h0, 3'h1, crst, 1'b0);
    chk("sign product", cond_word[14], s);
  endtask

  // Reset for 16 cycles, then run every scenario in turn.
  initial
  begin
    rst = 1'b1;
    core_id = 1'b0;
    channel_id = 1'b0;
    host_irq_status = 16'h0;
    exchange_in = 16'h0;
    exchange_in_valid = 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    #1;
    t_regs();
    t_dac();
    t_seq();
    run_add(2'h0, 1'b0, 16'hffff, 16'h0002, 16'h0001, 6'h04, 1'b1);
    run_add(2'h2, 1'b1, 16'h0001, 16'h0002, 16'hffff, 6'h18, 1'b0);
    run_add(2'h1, 1'b0, 16'h7fff, 16'h0001, 16'h7fff, 6'h01, 1'b0);
    run_add(2'h1, 1'b1, 16'h8000, 16'h0001, 16'h8000, 6'h12, 1'b0);
    run_add(2'h3, 1'b0, 16'hffff, 16'h0002, 16'hffff, 6'h14, 1'b1);
    run_add(2'h3, 1'b1, 16'h0001, 16'h0002, 16'h0000, 6'h28, 1'b0);
    dec.wr(mcalu_pkg::SEL_MASK, 16'h00ff);
    dec.wr(mcalu_pkg::SEL_GEN0, 16'hff00);
    run_mask(mcalu_pkg::MCALU_AND, 16'h0000, 2'b10);
    run_mask(mcalu_pkg::MCALU_OR, 16'hffff, 2'b01);
    run_mask(mcalu_pkg::MCALU_XOR, 16'hffff, 2'b01);
    run_mask(mcalu_pkg::MCALU_NOT, 16'hff00, 2'b00);
    t_mul();
    run_toint(16'hfffe, 1'b1, 1'b1);
    rdchk(mcalu_pkg::SEL_GEN1, 16'h0002);
    run_toint(16'hfffe, 1'b0, 1'b0);
    run_toint(16'h0003, 1'b0, 1'b0);
    run_toint(16'h8001, 1'b0, 1'b1);
    run_toint(16'h0005, 1'b1, 1'b0);
    t_imm();
    final_report();
  end
endmodule
